// ### hw/bes_consts.svh
// Purpose: Constants for the breakpoint event sequencer
// Assumes: 250 MHz clock
// Notes: Widths, limits and power-up values
`ifndef BES_CONSTS_SVH
`define BES_CONSTS_SVH
`define BES_EVT_W 15
`define BES_DLY_W 11
`define BES_ADDR_W 24
`define BES_EVT_MAX 15'h7fff
`define BES_DLY_MAX 11'h07ff
`define BES_EVT_RST 15'h0000
`define BES_DLY_RST 11'h0000
`define BES_MASK_RST 24'h00_ffff
`define BES_MASK_NARROW 24'h00_ffff
`define BES_MASK_WIDE 24'hff_ffff
`define BES_EXT_BITS_WIDE 4'h8
`define BES_TRACE_DEPTH_W 11
`endif

// ### hw/bes_pkg.sv
// Purpose: Types for the breakpoint event sequencer
// Assumes: Constants header included
// Notes: State and carriers
`default_nettype none
`include "bes_consts.svh"
package bes_pkg;
   typedef enum logic [1:0] {
      BES_IDLE,
      BES_COUNTING,
      BES_DELAYING,
      BES_HALTED
   } bes_state_t;

   typedef struct packed {
      logic valid;
      logic is_io;
      logic [`BES_ADDR_W-1:0] addr;
   } bes_cycle_t;

   typedef struct packed {
      logic mem_en;
      logic io_en;
      logic [`BES_ADDR_W-1:0] mem_addr;
      logic [`BES_ADDR_W-1:0] io_addr;
   } bes_define_t;

   typedef struct packed {
      logic [`BES_EVT_W-1:0] event_count;
      logic [`BES_DLY_W-1:0] delay_count;
      logic [`BES_ADDR_W-1:0] addr_mask;
      logic [3:0] ext_bits;
   } bes_config_t;
endpackage : bes_pkg
`default_nettype wire

// ### hw/bes_sequencer.sv
// Purpose: Hardware breakpoint event sequencer
// Assumes: One observed bus cycle per valid pulse
// Notes: Configuration arrives on plain ports with a load strobe
//
// Functional notes
// - An event needs an enabled memory condition on a memory cycle or an enabled I/O condition on an I/O cycle.
// - Event count 0..7fff, decremented by one per detected event.
// - At zero event count the delay counter starts, range 0..7ff.
// - Changed event count flushes trace at next single step or continue.
// - Mask 16 bits normally, 24 with eight extended bits, power-up FFFF.
// - Power-up event and delay counts are zero, others defaults.
// - After zero, store delay-count plus one samples, raising the breakpoint on the last.
// - Mask bit zero ignores that address bit, one requires a match.
`timescale 1ns/1ns
`default_nettype none
`include "bes_consts.svh"
module bes_sequencer
   import bes_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire bes_cycle_t bus_cycle,
   input wire bes_define_t event_define,
   input wire logic breakpoint_config_cmd,
   input wire bes_config_t config_in,
   input wire logic single_step_cmd,
   input wire logic continue_run_cmd,
   input wire logic [`BES_TRACE_DEPTH_W-1:0] trace_rd_addr,
   output logic [`BES_ADDR_W:0] trace_rd_data,
   output logic breakpoint_hit,
   output logic event_pulse,
   output logic delaying,
   output logic [`BES_EVT_W-1:0] event_left,
   output logic [`BES_DLY_W-1:0] delay_left,
   output logic [`BES_TRACE_DEPTH_W:0] trace_fill
);
   typedef struct packed {
      bes_state_t state;
      bes_config_t cfg;
      logic [`BES_EVT_W-1:0] evt;
      logic [`BES_DLY_W-1:0] dly;
      logic flush_pending;
      logic [`BES_TRACE_DEPTH_W-1:0] wr_ptr;
      logic [`BES_TRACE_DEPTH_W:0] fill;
      logic hit;
      logic ev;
      logic in_delay;
   } bes_regs_t;

   bes_regs_t s_reg;
   bes_regs_t s_next;
   logic mask_match_mem;
   logic mask_match_io;
   logic is_event;
   logic [`BES_ADDR_W-1:0] eff_mask;
   logic run_start;
   logic trace_wr;

   // Mask width follows the extended address bit count
   always_comb
   begin
      if (s_reg.cfg.ext_bits == `BES_EXT_BITS_WIDE)
      begin
         eff_mask = s_reg.cfg.addr_mask & `BES_MASK_WIDE;
      end
      else
      begin
         eff_mask = s_reg.cfg.addr_mask & `BES_MASK_NARROW;
      end
   end

   assign mask_match_mem = ((bus_cycle.addr ^ event_define.mem_addr) & eff_mask) == '0;
   assign mask_match_io = ((bus_cycle.addr ^ event_define.io_addr) & eff_mask) == '0;
   // Either enabled condition matching the cycle type, once per valid cycle
   assign is_event = bus_cycle.valid &&
      ((!bus_cycle.is_io && event_define.mem_en && mask_match_mem) ||
       (bus_cycle.is_io && event_define.io_en && mask_match_io));
   assign run_start = single_step_cmd || continue_run_cmd;
   assign trace_wr = bus_cycle.valid && (s_reg.state != BES_HALTED) &&
      (s_reg.state != BES_IDLE);

   always_comb
   begin
      s_next = s_reg;
      s_next.ev = 1'b0;
      if (breakpoint_config_cmd)
      begin
         if (config_in.event_count != s_reg.cfg.event_count)
         begin
            s_next.flush_pending = 1'b1;
         end
         s_next.cfg = config_in;
         s_next.evt = config_in.event_count;
         s_next.dly = config_in.delay_count;
         s_next.state = BES_IDLE;
         s_next.hit = 1'b0;
      end
      else if (run_start)
      begin
         if (s_reg.flush_pending)
         begin
            s_next.wr_ptr = '0;
            s_next.fill = '0;
            s_next.flush_pending = 1'b0;
         end
         s_next.evt = s_reg.cfg.event_count;
         s_next.dly = s_reg.cfg.delay_count;
         s_next.hit = 1'b0;
         s_next.state = (s_reg.cfg.event_count == '0) ? BES_DELAYING : BES_COUNTING;
      end
      else
      begin
         if (trace_wr)
         begin
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
            if (s_reg.fill != (`BES_TRACE_DEPTH_W+1)'(1 << `BES_TRACE_DEPTH_W))
            begin
               s_next.fill = s_reg.fill + 1'b1;
            end
         end
         case (s_reg.state)
            BES_IDLE:
            begin
               s_next.state = BES_IDLE;
            end
            BES_COUNTING:
            begin
               if (is_event)
               begin
                  s_next.ev = 1'b1;
                  s_next.evt = s_reg.evt - 1'b1;
                  if (s_reg.evt == `BES_EVT_W'(1))
                  begin
                     s_next.state = BES_DELAYING;
                  end
               end
            end
            BES_DELAYING:
            begin
               if (bus_cycle.valid)
               begin
                  if (s_reg.dly == '0)
                  begin
                     s_next.state = BES_HALTED;
                     s_next.hit = 1'b1;
                  end
                  else
                  begin
                     s_next.dly = s_reg.dly - 1'b1;
                  end
               end
            end
            BES_HALTED:
            begin
               s_next.hit = 1'b1;
            end
            default:
            begin
               s_next.state = BES_IDLE;
            end
         endcase
      end
      // Registered copy of the delay state for the output pin
      s_next.in_delay = (s_next.state == BES_DELAYING);
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_reg.state <= BES_IDLE;
         s_reg.cfg.event_count <= `BES_EVT_RST;
         s_reg.cfg.delay_count <= `BES_DLY_RST;
         s_reg.cfg.addr_mask <= `BES_MASK_RST;
         s_reg.cfg.ext_bits <= 4'h0;
         s_reg.evt <= `BES_EVT_RST;
         s_reg.dly <= `BES_DLY_RST;
         s_reg.flush_pending <= 1'b0;
         s_reg.wr_ptr <= '0;
         s_reg.fill <= '0;
         s_reg.hit <= 1'b0;
         s_reg.ev <= 1'b0;
         s_reg.in_delay <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   bes_trace_mem u_trace
   (
      .clock(clock),
      .wr_en(trace_wr && !breakpoint_config_cmd && !run_start),
      .wr_addr(s_reg.wr_ptr),
      .wr_data({bus_cycle.is_io, bus_cycle.addr}),
      .rd_addr(trace_rd_addr),
      .rd_data(trace_rd_data)
   );

   assign breakpoint_hit = s_reg.hit;
   assign event_pulse = s_reg.ev;
   assign delaying = s_reg.in_delay;
   assign event_left = s_reg.evt;
   assign delay_left = s_reg.dly;
   assign trace_fill = s_reg.fill;
endmodule : bes_sequencer
`default_nettype wire

// ### hw/bes_trace_mem.sv
// Purpose: Trace sample store for the sequencer
// Assumes: One write port, one registered read port
// Notes: Read data comes out of a register
`timescale 1ns/1ns
`default_nettype none
`include "bes_consts.svh"
module bes_trace_mem
   import bes_pkg::*;
(
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [`BES_TRACE_DEPTH_W-1:0] wr_addr,
   input wire logic [`BES_ADDR_W:0] wr_data,
   input wire logic [`BES_TRACE_DEPTH_W-1:0] rd_addr,
   output logic [`BES_ADDR_W:0] rd_data
);
   logic [`BES_ADDR_W:0] mem [0:(1<<`BES_TRACE_DEPTH_W)-1];

   always_ff @(posedge clock)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : bes_trace_mem
`default_nettype wire

// ### verification/bes_bus_model.sv
// Purpose: Target bus cycle source for the sequencer
// Assumes: One cycle per go request
// Notes: Idle lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
`include "bes_consts.svh"
module bes_bus_model
   import bes_pkg::*;
(
   input wire logic clock,
   input wire logic go,
   input wire logic is_io,
   input wire logic [`BES_ADDR_W-1:0] addr,
   output var bes_cycle_t bus_cycle
);
   initial bus_cycle = '0;
   always @(posedge clock)
   begin
      bus_cycle.valid <= go;
      bus_cycle.is_io <= go ? is_io : ~bus_cycle.is_io;
      bus_cycle.addr <= go ? addr : ~bus_cycle.addr;
   end
endmodule : bes_bus_model
`default_nettype wire

// ### verification/bes_sequencer_sva.sv
// Purpose: Port checks for the sequencer
// Assumes: Single clock domain
// Notes: Attached by bind
`timescale 1ns/1ns
`default_nettype none
`include "bes_consts.svh"
module bes_seq_sva
   import bes_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire bes_cycle_t bus_cycle,
   input wire logic breakpoint_config_cmd,
   input wire logic single_step_cmd,
   input wire logic continue_run_cmd,
   input wire logic breakpoint_hit,
   input wire logic event_pulse,
   input wire logic delaying,
   input wire logic [`BES_EVT_W-1:0] event_left,
   input wire logic [`BES_DLY_W-1:0] delay_left,
   input wire logic [`BES_TRACE_DEPTH_W:0] trace_fill
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   wire logic cmd = breakpoint_config_cmd | single_step_cmd | continue_run_cmd;
   chk_evt_step: assert property (event_pulse |-> event_left == $past(event_left) - 15'h0001)
      else $error("event count step wrong");
   chk_pulse_cause: assert property (event_pulse |-> $past(bus_cycle.valid))
      else $error("event without bus cycle");
   chk_hit_cause: assert property ($rose(breakpoint_hit) |->
      $past(delaying && bus_cycle.valid && delay_left == 0))
      else $error("breakpoint without delay end");
   chk_delay_entry: assert property ($rose(delaying) |-> event_left == 0)
      else $error("delay before event count zero");
   chk_delay_step: assert property (delaying && bus_cycle.valid
      && delay_left != 0 && !cmd |=> delay_left == $past(delay_left) - 11'h001)
      else $error("delay count step wrong");
   chk_idle_hold: assert property (!$past(bus_cycle.valid) && !$past(cmd)
      |-> $stable(event_left) && $stable(delay_left))
      else $error("count moved without bus cycle");
   chk_hit_hold: assert property (breakpoint_hit && !cmd |=> breakpoint_hit)
      else $error("breakpoint dropped");
   chk_reset_vals: assert property (disable iff (1'b0) sys_rst |=> event_left == 0
      && delay_left == 0 && !breakpoint_hit && trace_fill == 0 && !delaying && !event_pulse)
      else $error("power-up values wrong");
   cover property ($rose(breakpoint_hit));
   cover property ($rose(delaying));
   cover property (event_pulse);
endmodule : bes_seq_sva
bind bes_sequencer bes_seq_sva chk
(
   .clock(clock),
   .sys_rst(sys_rst),
   .bus_cycle(bus_cycle),
   .breakpoint_config_cmd(breakpoint_config_cmd),
   .single_step_cmd(single_step_cmd),
   .continue_run_cmd(continue_run_cmd),
   .breakpoint_hit(breakpoint_hit),
   .event_pulse(event_pulse),
   .delaying(delaying),
   .event_left(event_left),
   .delay_left(delay_left),
   .trace_fill(trace_fill)
);
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Bus cycles come from the bus model
// Notes: Results read three edges after each bus request, zero or one edge after a configuration load
`timescale 1ns/1ns
`default_nettype none
`include "bes_consts.svh"
`define CHK(n, e, s) \
   begin cmp_count++; if ((s) !== (e)) \
   begin $display("Error %s exp %0h got %0h", n, e, s); err_total++; end end
module testbench
   import bes_pkg::*;
;
   logic clock = 0, sys_rst = 1, go = 0, is_io = 0;
   logic breakpoint_config_cmd = 0, single_step_cmd = 0, continue_run_cmd = 0;
   logic [`BES_ADDR_W-1:0] addr = '0;
   logic [`BES_TRACE_DEPTH_W-1:0] trace_rd_addr = '0;
   bes_cycle_t bus_cycle;
   bes_define_t event_define = '{1'b1, 1'b0, 24'h00_1234, 24'h00_1230};
   bes_config_t config_in = '0;
   logic [`BES_ADDR_W:0] trace_rd_data;
   logic breakpoint_hit, event_pulse, delaying;
   logic [`BES_EVT_W-1:0] event_left;
   logic [`BES_DLY_W-1:0] delay_left;
   logic [`BES_TRACE_DEPTH_W:0] trace_fill;
   int err_total = 0, cmp_count = 0;
   always #2 clock = ~clock;
   bes_sequencer DUT
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .bus_cycle(bus_cycle),
      .event_define(event_define),
      .breakpoint_config_cmd(breakpoint_config_cmd),
      .config_in(config_in),
      .single_step_cmd(single_step_cmd),
      .continue_run_cmd(continue_run_cmd),
      .trace_rd_addr(trace_rd_addr),
      .trace_rd_data(trace_rd_data),
      .breakpoint_hit(breakpoint_hit),
      .event_pulse(event_pulse),
      .delaying(delaying),
      .event_left(event_left),
      .delay_left(delay_left),
      .trace_fill(trace_fill)
   );
   bes_bus_model model (.clock(clock), .go(go), .is_io(is_io), .addr(addr),
      .bus_cycle(bus_cycle));
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task load(input bes_config_t c, input bit s);
      config_in <= c;
      breakpoint_config_cmd <= 1;
      @(posedge clock);
      breakpoint_config_cmd <= 0;
      if (s) single_step_cmd <= 1;
      else continue_run_cmd <= 1;
      @(posedge clock);
      single_step_cmd <= 0;
      continue_run_cmd <= 0;
   endtask : load
   task bus(input logic io, input logic [`BES_ADDR_W-1:0] a, input int n);
      go <= 1;
      is_io <= io;
      addr <= a;
      cyc(n);
      go <= 0;
      cyc(3);
   endtask : bus
   task t_reset;
      `CHK("event_left", 15'h0000, event_left)
      `CHK("delay_left", 11'h000, delay_left)
      `CHK("hit", 1'b0, breakpoint_hit)
      `CHK("fill", 12'h000, trace_fill)
   endtask : t_reset
   task t_walk;
      load('{15'h0003, 11'h001, 24'h00_ffff, 4'h0}, 0);
      bus(0, 24'h00_1235, 1);
      `CHK("event_left", 15'h0003, event_left)
      bus(0, 24'h00_1234, 1);
      `CHK("event_left", 15'h0002, event_left)
      bus(0, 24'h00_1234, 2);
      `CHK("event_left", 15'h0000, event_left)
      `CHK("delaying", 1'b1, delaying)
      bus(0, 24'h00_0000, 1);
      `CHK("delay_left", 11'h000, delay_left)
      `CHK("hit", 1'b0, breakpoint_hit)
      bus(0, 24'h00_0000, 1);
      `CHK("hit", 1'b1, breakpoint_hit)
   endtask : t_walk
   task t_mask;
      load('{15'h0002, 11'h000, 24'h00_fff0, 4'h0}, 1);
      cyc(1);
      `CHK("fill", 12'h000, trace_fill)
      bus(0, 24'hab_123f, 1);
      `CHK("event_left", 15'h0001, event_left)
      `CHK("trace", 25'h0ab_123f, trace_rd_data)
      bus(1, 24'h00_1230, 1);
      `CHK("event_left", 15'h0001, event_left)
      trace_rd_addr <= 11'h001;
      cyc(2);
      `CHK("trace", 25'h100_1230, trace_rd_data)
      load('{15'h0002, 11'h000, 24'hff_fff0, 4'h8}, 0);
      `CHK("fill", 12'h002, trace_fill)
      bus(0, 24'hab_1230, 1);
      `CHK("event_left", 15'h0002, event_left)
      event_define.io_en <= 1;
      bus(1, 24'h00_1231, 1);
      `CHK("event_left", 15'h0001, event_left)
   endtask : t_mask
   task t_zero;
      load('{15'h0000, 11'h000, 24'h00_ffff, 4'h0}, 0);
      cyc(1);
      `CHK("delaying", 1'b1, delaying)
      `CHK("fill", 12'h000, trace_fill)
      bus(0, 24'h00_0000, 1);
      `CHK("hit", 1'b1, breakpoint_hit)
   endtask : t_zero
   task conclude;
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      cyc(6);
      sys_rst <= 0;
      cyc(1);
      t_reset;
      t_walk;
      t_mask;
      t_zero;
      conclude;
   end
   initial
   begin
      #4000;
      err_total++;
      conclude;
   end
endmodule : testbench
`default_nettype wire
